// file: hw/tco_cfg.svh
`ifndef TCO_CFG_SVH
`define TCO_CFG_SVH

// Register byte offsets.
`define TCO_ADDL3_OFS     8'h70
`define TCO_CTL_OFS       8'h74

// Reset values.
`define TCO_ADDL3_RST     16'h0000
`define TCO_CTL_RST       32'h0FF000FF

// Writable bits of the output control register; bits 19:16 stay zero.
`define TCO_CTL_MASK      32'hFFF0FFFF

// Field positions in the output control register.
`define TCO_CPWM_LSB      28
`define TCO_PAIR_LSB      20
`define TCO_PULSE_LSB     8
`define TCO_BRK_LSB       4
`define TCO_DTI_LSB       0
`define TCO_RSVD_MSB      19
`define TCO_RSVD_LSB      16

// Channel count and compare width.
`define TCO_NCH           4
`define TCO_CMP_W         16

`endif

// file: hw/tco_pkg.sv
package tco_pkg;

  typedef enum logic [1:0] {
    TCO_PAIR_INDEP  = 2'h0,
    TCO_PAIR_MIRROR = 2'h1,
    TCO_PAIR_RSVD   = 2'h2,
    TCO_PAIR_COMPL  = 2'h3
  } tco_pair_e;

  typedef enum logic [1:0] {
    TCO_PULSE_NORMAL = 2'h0,
    TCO_PULSE_UP     = 2'h1,
    TCO_PULSE_DOWN   = 2'h2,
    TCO_PULSE_BOTH   = 2'h3
  } tco_pulse_e;

endpackage : tco_pkg

// file: hw/tco_chan.sv
`timescale 1ns/10ps
module tco_chan (
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               rst_n_in,
  // Reference inputs from the compare stage
  input  wire logic               oref_in,
  input  wire logic               mm_ref_in,
  input  wire logic               match_in,
  input  wire logic               count_down_in,
  // Configuration
  input  tco_pkg::tco_pulse_e     pulse_sel_in,
  input  tco_pkg::tco_pair_e      pair_mode_in,
  // Outputs
  output logic                    ref_out,
  output logic                    primary_out,
  output logic                    paired_out
);

  logic match_q_r;
  logic edge_w;
  logic dir_ok_w;
  logic ref_nxt;
  logic paired_nxt;

  // A match held over several cycles still yields a single pulse.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      match_q_r <= 1'b0;
    end else begin
      match_q_r <= match_in;
    end
  end

  assign edge_w = match_in & ~match_q_r;

  always_comb begin
    case (pulse_sel_in)
      tco_pkg::TCO_PULSE_UP:   dir_ok_w = ~count_down_in;
      tco_pkg::TCO_PULSE_DOWN: dir_ok_w = count_down_in;
      tco_pkg::TCO_PULSE_BOTH: dir_ok_w = 1'b1;
      default:                 dir_ok_w = 1'b0;
    endcase
    if (pulse_sel_in == tco_pkg::TCO_PULSE_NORMAL) begin
      ref_nxt = oref_in;
    end else begin
      ref_nxt = edge_w & dir_ok_w;
    end
    case (pair_mode_in)
      tco_pkg::TCO_PAIR_MIRROR: paired_nxt = ref_nxt;
      tco_pkg::TCO_PAIR_COMPL:  paired_nxt = ~ref_nxt;
      default:                  paired_nxt = mm_ref_in;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_out     <= 1'b0;
      primary_out <= 1'b0;
      paired_out  <= 1'b0;
    end else begin
      ref_out     <= ref_nxt;
      primary_out <= ref_nxt;
      paired_out  <= paired_nxt;
    end
  end

  // With a steady pulse select, a pulse is always followed by a low cycle.
  chk_pulse_width: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (pulse_sel_in != tco_pkg::TCO_PULSE_NORMAL && $stable(pulse_sel_in)
      && ref_out) |=> !ref_out)
    else $error("match pulse wider than one cycle");

  chk_pulse_down: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (pulse_sel_in == tco_pkg::TCO_PULSE_DOWN && edge_w && count_down_in
      && $stable(pulse_sel_in)) |=> ref_out)
    else $error("down-count match gave no pulse");

  chk_pair_compl: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (pair_mode_in == tco_pkg::TCO_PAIR_COMPL) |=>
      (paired_out != primary_out))
    else $error("complementary outputs not inverse");

  chk_pair_mirror: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (pair_mode_in == tco_pkg::TCO_PAIR_MIRROR) |=>
      (paired_out == primary_out))
    else $error("mirrored output differs from primary");

endmodule : tco_chan

// file: hw/tco_top.sv
// Summary of operation
// - Channel 3 output mode compares its 16-bit additional value with counter.
// - With shadowing on, the active additional value loads only at update.
// - Additional compare of channel 3 acts only when its composite bit is 1.
// - Composite enables sit at bits 31..28 for channels 3..0; 1 enables.
// - Pair select fields at 27:26, 25:24, 23:22, 21:20 for pairs 3..0.
// - Pair select 00 keeps the multi-mode channel independent.
// - Pair select 01 makes the multi-mode output mirror the primary output.
// - Pair select 11 gives complementary outputs, primary only as input; 10 reserved.
// - Match-pulse select 00 passes the normal output reference; ch3 at 15:14.
// - Select 01 gives a one-cycle pulse on match while counting up.
// - Select 10 gives a one-cycle pulse on match while counting down.
// - Select 11 gives a one-cycle pulse on every match, either direction.
// - Dead-time enable bits 3..0 act on both outputs of each pair.
// - Break enable bits 7..4 put each channel under break control.
`timescale 1ns/10ps
`include "tco_cfg.svh"
module tco_top (
  // Clock and reset
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  // Register port
  input  wire logic [7:0]                reg_addr_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  input  wire logic [31:0]               reg_wdata_in,
  output logic      [31:0]               reg_rdata_out,
  // Counter and update interface
  input  wire logic [`TCO_CMP_W-1:0]     counter_in,
  input  wire logic                      count_down_in,
  input  wire logic                      update_event_in,
  input  wire logic                      addl_shadow_en_in,
  input  wire logic                      ch3_output_mode_in,
  // Per-channel references from the compare stage
  input  wire logic [`TCO_NCH-1:0]       oref_in,
  input  wire logic [`TCO_NCH-1:0]       mm_ref_in,
  input  wire logic [`TCO_NCH-1:0]       match_in,
  // Channel outputs
  output logic [`TCO_NCH-1:0]            output_reference_out,
  output logic [`TCO_NCH-1:0]            primary_out,
  output logic [`TCO_NCH-1:0]            paired_out,
  output logic [`TCO_NCH-1:0]            paired_input_en_out,
  // Control levels for the dead-time and break stages
  output logic [`TCO_NCH-1:0]            composite_pwm_enable_out,
  output logic [`TCO_NCH-1:0]            deadtime_insert_enable_out,
  output logic [`TCO_NCH-1:0]            break_gate_enable_out,
  // Additional compare match of channel 3
  output logic                           addl_match_3_out
);

  logic [`TCO_CMP_W-1:0] addl_preload_r;
  logic [`TCO_CMP_W-1:0] addl_active_r;
  logic [31:0]           ctl_r;
  logic [31:0]           rdata_nxt;
  logic                  wr_addl_w;
  logic                  wr_ctl_w;
  logic                  addl_match_nxt;
  logic [`TCO_NCH-1:0]   pin_en_nxt;

  // The port carries no byte lanes; every write is taken as a whole word.
  assign wr_addl_w = reg_wr_in && (reg_addr_in == `TCO_ADDL3_OFS);
  assign wr_ctl_w  = reg_wr_in && (reg_addr_in == `TCO_CTL_OFS);

  // Preload register: what software wrote, and what it reads back.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addl_preload_r <= `TCO_ADDL3_RST;
    end else if (wr_addl_w) begin
      addl_preload_r <= reg_wdata_in[`TCO_CMP_W-1:0];
    end
  end

  // Active compare value. With shadowing on, a write and an update in the
  // same cycle load the old preload; the new value waits for the next update.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addl_active_r <= `TCO_ADDL3_RST;
    end else if (addl_shadow_en_in) begin
      if (update_event_in) begin
        addl_active_r <= addl_preload_r;
      end
    end else if (wr_addl_w) begin
      addl_active_r <= reg_wdata_in[`TCO_CMP_W-1:0];
    end
  end

  // Reserved bits are masked rather than stored, so they always read zero.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_r <= `TCO_CTL_RST;
    end else if (wr_ctl_w) begin
      ctl_r <= reg_wdata_in & `TCO_CTL_MASK;
    end
  end

  always_comb begin
    case (reg_addr_in)
      `TCO_ADDL3_OFS: rdata_nxt = {16'h0000, addl_preload_r};
      `TCO_CTL_OFS:   rdata_nxt = ctl_r;
      default:        rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  // Additional compare runs only in composite mode with channel 3 driving.
  assign addl_match_nxt = ctl_r[`TCO_CPWM_LSB+3] && ch3_output_mode_in
                          && (counter_in == addl_active_r);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addl_match_3_out <= 1'b0;
    end else begin
      addl_match_3_out <= addl_match_nxt;
    end
  end

  // Control levels handed on to the dead-time and break stages.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      composite_pwm_enable_out   <= 4'h0;
      deadtime_insert_enable_out <= 4'h0;
      break_gate_enable_out      <= 4'h0;
      paired_input_en_out        <= 4'h0;
    end else begin
      composite_pwm_enable_out   <= ctl_r[`TCO_CPWM_LSB+:`TCO_NCH];
      deadtime_insert_enable_out <= ctl_r[`TCO_DTI_LSB+:`TCO_NCH];
      break_gate_enable_out      <= ctl_r[`TCO_BRK_LSB+:`TCO_NCH];
      paired_input_en_out        <= pin_en_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `TCO_NCH; gi = gi + 1) begin : g_ch
      tco_pkg::tco_pair_e  pair_w;
      tco_pkg::tco_pulse_e pulse_w;

      assign pair_w  = tco_pkg::tco_pair_e'(
                         ctl_r[`TCO_PAIR_LSB+2*gi+:2]);
      assign pulse_w = tco_pkg::tco_pulse_e'(
                         ctl_r[`TCO_PULSE_LSB+2*gi+:2]);
      // Only independent pairing lets the multi-mode channel capture.
      assign pin_en_nxt[gi] = (pair_w == tco_pkg::TCO_PAIR_INDEP);

      tco_chan u_chan (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .oref_in       (oref_in[gi]),
        .mm_ref_in     (mm_ref_in[gi]),
        .match_in      (match_in[gi]),
        .count_down_in (count_down_in),
        .pulse_sel_in  (pulse_w),
        .pair_mode_in  (pair_w),
        .ref_out       (output_reference_out[gi]),
        .primary_out   (primary_out[gi]),
        .paired_out    (paired_out[gi])
      );
    end
  endgenerate

  sequence s_shadow_quiet;
    addl_shadow_en_in && !update_event_in;
  endsequence

  sequence s_shadow_update;
    addl_shadow_en_in && update_event_in;
  endsequence

  sequence s_direct_write;
    !addl_shadow_en_in && wr_addl_w;
  endsequence

  chk_shadow_hold: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    s_shadow_quiet |=> $stable(addl_active_r))
    else $error("active value moved without update");

  chk_shadow_load: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    s_shadow_update |=> (addl_active_r == $past(addl_preload_r)))
    else $error("update did not load preload value");

  chk_direct_write: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    s_direct_write |=>
      (addl_active_r == $past(reg_wdata_in[`TCO_CMP_W-1:0])))
    else $error("unshadowed write not applied");

  chk_addl_gate: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (!ctl_r[`TCO_CPWM_LSB+3] || !ch3_output_mode_in) |=> !addl_match_3_out)
    else $error("additional match outside composite mode");

  chk_addl_match: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (ctl_r[`TCO_CPWM_LSB+3] && ch3_output_mode_in
      && counter_in == addl_active_r) |=> addl_match_3_out)
    else $error("additional compare match missed");

  chk_rsvd_zero: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    ctl_r[`TCO_RSVD_MSB:`TCO_RSVD_LSB] == 4'h0)
    else $error("reserved control bits not zero");

  chk_enable_copy: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    wr_ctl_w |=> ##1
      (deadtime_insert_enable_out == $past(reg_wdata_in[3:0], 2))
      && (break_gate_enable_out == $past(reg_wdata_in[7:4], 2))
      && (composite_pwm_enable_out == $past(reg_wdata_in[31:28], 2)))
    else $error("enable levels do not follow control write");

  chk_read_ctl: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_addr_in == `TCO_CTL_OFS) |=>
      (reg_rdata_out == $past(ctl_r)))
    else $error("control read returned wrong value");

  chk_input_sel: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    (ctl_r[27:26] == 2'h3) |=> !paired_input_en_out[3])
    else $error("complementary pair left multi-mode input on");

endmodule : tco_top

// file: testbench/tco_top_tb.sv
`timescale 1ns/10ps
`include "tco_cfg.svh"
module tco_top_tb;
  logic        clock_in;
  logic        rst_n_in;
  logic [7:0]  reg_addr_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [31:0] reg_wdata_in;
  logic [31:0] reg_rdata_out;
  logic [15:0] counter_in;
  logic        count_down_in;
  logic        update_event_in;
  logic        addl_shadow_en_in;
  logic        ch3_output_mode_in;
  logic [3:0]  oref_in;
  logic [3:0]  mm_ref_in;
  logic [3:0]  match_in;
  logic [3:0]  ref_o;
  logic [3:0]  prim_o;
  logic [3:0]  pair_o;
  logic [3:0]  pin_o;
  logic [3:0]  cpwm_o;
  logic [3:0]  dti_o;
  logic [3:0]  brk_o;
  logic        addl_o;
  int          mismatches;
  int          checks_done;

  tco_top tco_top_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .counter_in(counter_in),
    .count_down_in(count_down_in), .update_event_in(update_event_in),
    .addl_shadow_en_in(addl_shadow_en_in),
    .ch3_output_mode_in(ch3_output_mode_in), .oref_in(oref_in),
    .mm_ref_in(mm_ref_in), .match_in(match_in),
    .output_reference_out(ref_o), .primary_out(prim_o),
    .paired_out(pair_o), .paired_input_en_out(pin_o),
    .composite_pwm_enable_out(cpwm_o),
    .deadtime_insert_enable_out(dti_o),
    .break_gate_enable_out(brk_o), .addl_match_3_out(addl_o));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask : tick

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Full-word accesses only; strobes drop at the next falling edge.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in = a; reg_wdata_in = d; reg_wr_in = 1'b1;
    tick(1);
    reg_wr_in = 1'b0;
    tick(2);
  endtask : reg_write

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_in = a; reg_rd_in = 1'b1;
    tick(1);
    reg_rd_in = 1'b0;
    tick(1);
    check("rdata", exp, reg_rdata_out);
  endtask : reg_check

  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic test_fields();
    reg_check(`TCO_CTL_OFS, 32'h0FF000FF);
    reg_check(`TCO_ADDL3_OFS, 32'h00000000);
    check("cpwm", 32'h0, {28'h0, cpwm_o});
    check("dti", 32'hF, {28'h0, dti_o});
    check("brk", 32'hF, {28'h0, brk_o});
    reg_write(`TCO_CTL_OFS, 32'hA6C0C35A);
    reg_check(`TCO_CTL_OFS, 32'hA6C0C35A);
    check("cpwm", 32'hA, {28'h0, cpwm_o});
    check("dti", 32'hA, {28'h0, dti_o});
    check("brk", 32'h5, {28'h0, brk_o});
    reg_check(8'h7C, 32'h00000000);
  endtask : test_fields

  task automatic test_pairing();
    logic [3:0] exp;
    for (int c = 0; c < 4; c++) begin
      reg_write(`TCO_CTL_OFS, {4'h0, {4{c[1:0]}}, 12'h000, 8'hFF});
      oref_in = 4'h6; mm_ref_in = 4'h3;
      tick(2);
      exp = (c == 1) ? 4'h6 : (c == 3) ? 4'h9 : 4'h3;
      check("paired", {28'h0, exp}, {28'h0, pair_o});
      check("primary", 32'h6, {28'h0, prim_o});
      check("pin_en", (c == 0) ? 32'hF : 32'h0, {28'h0, pin_o});
    end
    oref_in = 4'h0; mm_ref_in = 4'h0;
  endtask : test_pairing

  task automatic test_pulse();
    int ones;
    int exp;
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 2; d++) begin
        reg_write(`TCO_CTL_OFS, {16'h0FF0, {4{s[1:0]}}, 8'hFF});
        count_down_in = d[0];
        match_in = 4'hF;
        ones = 0;
        for (int k = 0; k < 5; k++) begin
          tick(1);
          if (ref_o === 4'hF) ones++;
          else if (ref_o !== 4'h0) ones += 10;
        end
        exp = (s == 3 || (s == 1 && d == 0) || (s == 2 && d == 1)) ? 1 : 0;
        check("pulses", exp, ones);
        match_in = 4'h0;
        tick(2);
      end
    end
    reg_write(`TCO_CTL_OFS, 32'h0FF000FF);
    oref_in = 4'h5;
    tick(2);
    check("reference", 32'h5, {28'h0, ref_o});
    oref_in = 4'h0;
  endtask : test_pulse

  task automatic test_addl();
    reg_write(`TCO_CTL_OFS, 32'h8FF000FF);
    reg_write(`TCO_ADDL3_OFS, 32'h00001234);
    reg_check(`TCO_ADDL3_OFS, 32'h00001234);
    counter_in = 16'h1234;
    tick(2);
    check("addl hit", 32'h1, {31'h0, addl_o});
    counter_in = 16'h1235;
    tick(2);
    check("addl miss", 32'h0, {31'h0, addl_o});
    counter_in = 16'h1234; ch3_output_mode_in = 1'b0;
    tick(2);
    check("addl input", 32'h0, {31'h0, addl_o});
    ch3_output_mode_in = 1'b1;
    reg_write(`TCO_CTL_OFS, 32'h0FF000FF);
    check("addl off", 32'h0, {31'h0, addl_o});
    reg_write(`TCO_CTL_OFS, 32'h8FF000FF);
    addl_shadow_en_in = 1'b1;
    reg_write(`TCO_ADDL3_OFS, 32'h00004321);
    counter_in = 16'h4321;
    tick(3);
    check("addl preload", 32'h0, {31'h0, addl_o});
    reg_check(`TCO_ADDL3_OFS, 32'h00004321);
    update_event_in = 1'b1;
    tick(1);
    update_event_in = 1'b0;
    tick(2);
    check("addl update", 32'h1, {31'h0, addl_o});
  endtask : test_addl

  // Whole run is under two hundred cycles; this margin only trips on a hang.
  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  initial begin
    mismatches = 0; checks_done = 0;
    rst_n_in = 1'b0; reg_addr_in = 8'h00; reg_wr_in = 1'b0;
    reg_rd_in = 1'b0; reg_wdata_in = 32'h0; counter_in = 16'h0;
    count_down_in = 1'b0; update_event_in = 1'b0;
    addl_shadow_en_in = 1'b0; ch3_output_mode_in = 1'b1;
    oref_in = 4'h0; mm_ref_in = 4'h0; match_in = 4'h0;
    tick(8);
    rst_n_in = 1'b1;
    tick(1);
    test_fields();
    test_pairing();
    test_pulse();
    test_addl();
    conclude();
  end
endmodule : tco_top_tb
